/* design/dpm_mixer.sv */
// dual product mixer: delay stacks, two multipliers, accumulator, output
//
// Overview of operation
// RULE1 - two 12x12 multipliers feed 24-bit accumulator
// RULE2 - everything rising-edge registered except output enable
// RULE3 - operand latched, then pushed into stack
// RULE4 - low enable pushes stack; high freezes it
// RULE5 - stage select picks delay one to sixteen
// RULE6 - host initialises selects and stacks first
// RULE7 - invert controls negate each product
// RULE8 - invert controls aligned with zero-delay operands
// RULE9 - chain input added only when enabled
// RULE10 - chain delayed three stages unless bypassed
// RULE11 - keep low restarts sum, high accumulates
// RULE12 - round only on first accumulation cycle
// RULE13 - word select picks upper or alternating words
// RULE14 - low word select holds output register value
// RULE15 - output enable low drives, high floats
// RULE16 - output register refreshed every cycle normally
// RULE17 - controls pipelined in step with data
// RULE18 - rounding adds half lsb at bit seven
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module dpm_mixer import dpm_pkg::*; (
  input  wire logic            pclk,
  input  wire logic            presetn,
  // operand ports
  input  wire logic [OPW-1:0]  operand_a,
  input  wire logic [OPW-1:0]  operand_b,
  input  wire logic [OPW-1:0]  operand_c,
  input  wire logic [OPW-1:0]  operand_d,
  input  wire logic [NOPS-1:0] stack_push_enable_n,
  input  wire logic [SELW-1:0] stage_select_a,
  input  wire logic [SELW-1:0] stage_select_b,
  input  wire logic [SELW-1:0] stage_select_c,
  input  wire logic [SELW-1:0] stage_select_d,
  // controls
  input  wire logic            product_ab_invert,
  input  wire logic            product_cd_invert,
  input  wire logic [CHW-1:0]  chain_input,
  input  wire logic            chain_input_enable_n,
  input  wire logic            cascade_bypass,
  input  wire logic            sum_keep_control,
  input  wire logic            round_control,
  input  wire logic            word_select,
  input  wire logic            three_state_control_n,
  // three-state result pin
  output logic      [OUTW-1:0] sum_output_out,
  output logic                 sum_output_oe,
  // capture fifo fill side
  output logic                 capture_ready,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr
);
  // ==========================================================
  // operand input registers and delay stacks
  logic [OPW-1:0]  op_in   [NOPS];
  logic [SELW-1:0] sel_in  [NOPS];
  logic [OPW-1:0]  op_ff   [NOPS];
  logic [SELW-1:0] sel_ff  [NOPS];
  logic [OPW-1:0]  op_dly  [NOPS];

  assign op_in  = '{operand_a, operand_b, operand_c, operand_d};
  assign sel_in = '{stage_select_a, stage_select_b, stage_select_c, stage_select_d};

  // selects and stacks start at zero here; host still must load them
  for (genvar k = 0; k < NOPS; k++) begin : g_op
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        op_ff[k]  <= '0;
        sel_ff[k] <= '0;
      end else begin
        op_ff[k]  <= op_in[k]; // [RULE3] input register loads every edge; only the push is gated
        sel_ff[k] <= sel_in[k]; // [RULE5]
      end
    end
    dpm_stack u_stack (
      .pclk    (pclk),
      .presetn (presetn),
      .push_n  (stack_push_enable_n[k]),
      .din     (op_ff[k]),
      .sel     (sel_ff[k]),
      .dout    (op_dly[k])
    );
  end

  // ==========================================================
  // control pipeline, one stage per datapath stage
  logic [CTLW-1:0] ctl_in;
  logic [CTLW-1:0] ctl_ff [CTL_DEP];

  assign ctl_in = {word_select, cascade_bypass, round_control,
                   sum_keep_control, product_cd_invert, product_ab_invert};

  // controls ride alongside the data so they act in step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < CTL_DEP; i++) ctl_ff[i] <= '0;
    end else begin
      ctl_ff[0] <= ctl_in; // [RULE17]
      for (int i = 1; i < CTL_DEP; i++) ctl_ff[i] <= ctl_ff[i-1];
    end
  end

  // ==========================================================
  // multipliers with optional negation
  logic signed [ACCW-1:0] raw_ab;
  logic signed [ACCW-1:0] raw_cd;
  logic signed [ACCW-1:0] term_ab;
  logic signed [ACCW-1:0] term_cd;
  logic signed [ACCW-1:0] prod_ab_ff;
  logic signed [ACCW-1:0] prod_cd_ff;
  logic signed [ACCW-1:0] psum_ff;

  assign raw_ab = ACCW'($signed(op_dly[0]) * $signed(op_dly[1])); // [RULE1]
  assign raw_cd = ACCW'($signed(op_dly[2]) * $signed(op_dly[3])); // [RULE1]
  // invert bits tapped so zero-delay operands see their own controls
  assign term_ab = ctl_ff[TAP_NEG][CTL_NAB] ? -raw_ab : raw_ab; // [RULE7] [RULE8]
  assign term_cd = ctl_ff[TAP_NEG][CTL_NCD] ? -raw_cd : raw_cd; // [RULE7] [RULE8]

  // product then product-sum registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prod_ab_ff <= '0;
      prod_cd_ff <= '0;
      psum_ff    <= '0;
    end else begin
      prod_ab_ff <= term_ab;
      prod_cd_ff <= term_cd;
      psum_ff    <= prod_ab_ff + prod_cd_ff; // [RULE1]
    end
  end

  // ==========================================================
  // cascade input path
  logic [CHW-1:0] chain_ff;
  logic [CHW-1:0] chain_dly_ff [CAS_DLY];
  logic [CHW-1:0] chain_sel;

  // a disabled chain port contributes zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_ff <= '0;
      for (int i = 0; i < CAS_DLY; i++) chain_dly_ff[i] <= '0;
    end else begin
      chain_ff <= chain_input_enable_n ? '0 : chain_input; // [RULE9]
      chain_dly_ff[0] <= chain_ff; // [RULE10]
      for (int i = 1; i < CAS_DLY; i++) chain_dly_ff[i] <= chain_dly_ff[i-1];
    end
  end

  // bypass lets a downstream part take the chain without the skew
  assign chain_sel = ctl_ff[TAP_ACC][CTL_BYP] ? chain_ff : chain_dly_ff[CAS_DLY-1]; // [RULE10]

  // ==========================================================
  // accumulator
  logic signed [ACCW-1:0] chain_term;
  logic signed [ACCW-1:0] round_add;
  logic signed [ACCW-1:0] step_sum;
  logic signed [ACCW-1:0] acc_ff;
  logic                   keep_now;

  // chain carries an upstream upper word, so it lines up with bit 8
  assign chain_term = ACCW'($signed(chain_sel)) <<< CAS_SHIFT;
  assign keep_now   = ctl_ff[TAP_ACC][CTL_KEEP];
  // rounding only when a new sum starts, so error does not build up
  assign round_add  = (ctl_ff[TAP_ACC][CTL_RND] && !keep_now) ?
                      ACCW'(1) <<< RND_BIT : '0; // [RULE12] [RULE18]
  assign step_sum   = psum_ff + chain_term + round_add; // [RULE9]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff <= '0;
    end else begin
      acc_ff <= keep_now ? acc_ff + step_sum : step_sum; // [RULE11]
    end
  end

  // ==========================================================
  // output register with word selection
  logic [ACCW-1:0] hold_ff;
  logic [OUTW-1:0] out_word_ff;
  logic            low_phase_ff;
  logic            ws_now;

  assign ws_now = ctl_ff[TAP_WS][CTL_WS];

  // held value alternates lower/upper while word select is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff      <= '0;
      out_word_ff  <= '0;
      low_phase_ff <= 1'b0;
    end else if (ws_now) begin
      hold_ff      <= acc_ff; // [RULE16]
      out_word_ff  <= acc_ff[ACCW-1 -: OUTW]; // [RULE13]
      low_phase_ff <= 1'b1;
    end else begin
      out_word_ff  <= low_phase_ff ? hold_ff[OUTW-1:0] : hold_ff[ACCW-1 -: OUTW]; // [RULE14]
      low_phase_ff <= !low_phase_ff; // [RULE13]
    end
  end

  // output enable acts without the clock
  assign sum_output_out = out_word_ff; // [RULE15]
  assign sum_output_oe  = !three_state_control_n; // [RULE2] [RULE15]

  // ==========================================================
  // capture fifo and apb registers
  logic              capture_ff;
  logic              ovf_ff;
  logic              fifo_valid;
  logic              fifo_pop;
  logic [FIFO_W-1:0] fifo_data;
  logic [4:0]        fifo_level;
  logic              rd_ok_ff;
  logic              setup_ph;
  logic              access_ph;
  logic              addr_ok;

  dpm_fifo #(.W(FIFO_W), .DEP(FIFO_DEP)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (capture_ff),
    .in_ready  (capture_ready),
    .in_data   (out_word_ff),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data),
    .level     (fifo_level)
  );

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign addr_ok   = (paddr == REG_CTRL) || (paddr == REG_STATUS) || (paddr == REG_DATA);
  assign pready    = access_ph;
  assign pslverr   = access_ph && !addr_ok;
  // pop only a word that was already present when the read was set up
  assign fifo_pop  = access_ph && !pwrite && (paddr == REG_DATA) && rd_ok_ff;

  // control register and sticky overflow; a new overflow beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_ff <= CTRL_RESET;
      ovf_ff     <= 1'b0;
    end else begin
      if (access_ph && pwrite && paddr == REG_CTRL) capture_ff <= pwdata[CTRL_CAPTURE];
      if (capture_ff && !capture_ready) ovf_ff <= 1'b1;
      else if (access_ph && pwrite && paddr == REG_STATUS && pwdata[STAT_OVF]) ovf_ff <= 1'b0;
    end
  end

  // read data captured in the setup cycle, so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata   <= '0;
      rd_ok_ff <= 1'b0;
    end else if (setup_ph) begin
      rd_ok_ff <= fifo_valid;
      prdata   <= '0;
      if (!pwrite) begin
        case (paddr)
          REG_CTRL:   prdata[CTRL_CAPTURE] <= capture_ff;
          REG_STATUS: begin
            prdata[STAT_EMPTY]                  <= !fifo_valid;
            prdata[STAT_FULL]                   <= !capture_ready;
            prdata[STAT_OVF]                    <= ovf_ff;
            prdata[STAT_LVL_LSB +: 5]           <= fifo_level;
          end
          REG_DATA:   prdata[FIFO_W-1:0] <= fifo_valid ? fifo_data : '0;
          default:    prdata <= '0;
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  sequence s_ws_low3;
    !ws_now [*3];
  endsequence

  a_neg_ab_term: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
    ctl_ff[TAP_NEG][CTL_NAB] |=> prod_ab_ff == -$past(raw_ab))
    else $error("ab product not negated");
  a_neg_align: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    ##2 ctl_ff[TAP_NEG][CTL_NCD] == $past(product_cd_invert, 2))
    else $error("cd invert misaligned");
  a_chain_gate: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
    chain_input_enable_n |=> chain_ff == '0)
    else $error("disabled chain input leaked");
  a_chain_delay: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
    ##3 !ctl_ff[TAP_ACC][CTL_BYP] |-> chain_sel == $past(chain_ff, 3))
    else $error("chain delay not three");
  a_acc_keep: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
    keep_now |=> acc_ff == $past(acc_ff) + $past(step_sum))
    else $error("accumulate lost running sum");
  a_round_once: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
    keep_now |=> acc_ff == $past(acc_ff) + $past(psum_ff) + $past(chain_term))
    else $error("rounding inside accumulation");
  a_word_upper: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
    ws_now |=> out_word_ff == $past(acc_ff[ACCW-1 -: OUTW]))
    else $error("upper word not shown");
  a_word_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
    s_ws_low3 |=> out_word_ff == $past(out_word_ff, 2) && $stable(hold_ff))
    else $error("held output not alternating");
  a_drive_tri: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
    sum_output_oe |-> !three_state_control_n && sum_output_out == out_word_ff)
    else $error("output drive mismatch");
endmodule // dpm_mixer
`default_nettype wire

/* inc/dpm_pkg.sv */
// constants shared by the dual product mixer design files
package dpm_pkg;
  // datapath widths and depths
  localparam int OPW        = 12;
  localparam int NOPS       = 4;
  localparam int STACK_DEP  = 16;
  localparam int SELW       = 4;
  localparam int CHW        = 16;
  localparam int ACCW       = 24;
  localparam int OUTW       = 16;
  localparam int CAS_DLY    = 3;
  localparam int RND_BIT    = 7;
  localparam int CAS_SHIFT  = 8;
  // control pipeline bit positions and stage taps
  localparam int CTL_NAB    = 0;
  localparam int CTL_NCD    = 1;
  localparam int CTL_KEEP   = 2;
  localparam int CTL_RND    = 3;
  localparam int CTL_BYP    = 4;
  localparam int CTL_WS     = 5;
  localparam int CTLW       = 6;
  localparam int CTL_DEP    = 5;
  localparam int TAP_NEG    = 1;
  localparam int TAP_ACC    = 3;
  localparam int TAP_WS     = 4;
  // capture fifo
  localparam int FIFO_W     = 16;
  localparam int FIFO_DEP   = 16;
  // apb register map (byte addresses) and fields
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam int CTRL_CAPTURE = 0;
  localparam int STAT_EMPTY   = 0;
  localparam int STAT_FULL    = 1;
  localparam int STAT_OVF     = 2;
  localparam int STAT_LVL_LSB = 4;
  localparam logic CTRL_RESET = 1'b0;
endpackage

/* design/dpm_stack.sv */
// one 16-stage operand delay stack with stage select
`timescale 1ns/1ps
`default_nettype none
module dpm_stack import dpm_pkg::*; (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            push_n,
  input  wire logic [OPW-1:0]  din,
  input  wire logic [SELW-1:0] sel,
  output logic      [OPW-1:0]  dout
);
  logic [OPW-1:0] stage_ff [STACK_DEP];

  // push on low enable, older entries move down; frozen otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < STACK_DEP; i++) stage_ff[i] <= '0;
    end else if (!push_n) begin // [RULE4]
      stage_ff[0] <= din; // [RULE3]
      for (int i = 1; i < STACK_DEP; i++) stage_ff[i] <= stage_ff[i-1];
    end
  end

  // stage 0 is one cycle behind the input register, stage 15 sixteen
  assign dout = stage_ff[sel]; // [RULE5]

  a_push_top: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
    !push_n |=> stage_ff[0] == $past(din) && stage_ff[1] == $past(stage_ff[0]))
    else $error("stack push did not shift");
  a_stack_frozen: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
    push_n |=> stage_ff[STACK_DEP-1] == $past(stage_ff[STACK_DEP-1]) && $stable(stage_ff[0]))
    else $error("stack moved while disabled");
endmodule // dpm_stack
`default_nettype wire

/* design/dpm_fifo.sv */
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dpm_fifo #(
  parameter int W   = 16,
  parameter int DEP = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data,
  output logic [$clog2(DEP):0] level
);
  localparam int AW = $clog2(DEP);
  logic [W-1:0]  mem_ff [DEP];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;

  // honest flags straight from the occupancy count
  assign in_ready  = (cnt_ff != (AW+1)'(DEP));
  assign out_valid = (cnt_ff != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[rd_ff];
  assign level     = cnt_ff;

  // storage write
  always_ff @(posedge pclk) begin
    if (push) mem_ff[wr_ff] <= in_data;
  end

  // pointers and count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wr_ff <= wr_ff + 1'b1;
      if (pop) rd_ff <= rd_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_bound: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_ff == (AW+1)'(DEP) |=> !(cnt_ff > (AW+1)'(DEP)))
    else $error("fifo count overran depth");
endmodule // dpm_fifo
`default_nettype wire

/* tb/dpm_link.sv */
// far-side partner: upstream cascade source and pulled-up result bus
`timescale 1ns/1ps
`default_nettype none
module dpm_link import dpm_pkg::*; (
  input  wire logic            pclk,
  input  wire logic            en_n,
  input  wire logic [CHW-1:0]  val,
  input  wire logic [OUTW-1:0] s_out,
  input  wire logic            s_oe,
  output logic      [CHW-1:0]  chain,
  output logic      [OUTW-1:0] bus
);
  logic [CHW-1:0] junk_ff = 16'h1234;
  // ==========================================================
  // cascade port
  // idle word changes every cycle so a stale value cannot pass for a match
  always_ff @(posedge pclk) begin
    junk_ff <= junk_ff + 16'h3b5d;
  end
  assign chain = en_n ? junk_ff : val;
  // ==========================================================
  // result bus
  // released bus is pulled up, never left at the last driven value
  assign bus = s_oe ? s_out : 16'hffff;
endmodule // dpm_link
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the dual product mixer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %h seen %h", nm, e, g); end end
module tb import dpm_pkg::*; ();
  localparam logic [47:0] OPX = {12'h100, 12'h001, 24'h0};
  localparam logic [47:0] OPY = {12'h200, 12'h003, 24'h0};
  localparam logic [47:0] OPR = {12'h180, 12'h001, 24'h0};
  localparam logic [47:0] OPN = {12'h100, 12'h100, 12'h100, 12'h080};
  logic            pclk = 1'b0;
  logic            presetn, ch_en_n, byp, keep, rnd, neg_ab, neg_cd, ws, ts_n;
  logic [OPW-1:0]  a, b, c, d;
  logic [NOPS-1:0] push_n;
  logic [SELW-1:0] sel;
  logic [CHW-1:0]  chv, chain;
  logic [OUTW-1:0] s_out, bus;
  logic            s_oe, cap_rdy, psel, penable, pwrite, pready, pslverr, erv;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata, rdv;
  int              fails = 0;
  int              samples_checked = 0;
  logic [OUTW-1:0] inv_exp [4] = '{16'h0180, 16'h0080, 16'hff80, 16'hfe80};
  int              dly [3] = '{0, 5, 15};

  dpm_mixer dut (
    .pclk(pclk), .presetn(presetn), .operand_a(a), .operand_b(b), .operand_c(c),
    .operand_d(d), .stack_push_enable_n(push_n), .stage_select_a(sel),
    .stage_select_b(sel), .stage_select_c(sel), .stage_select_d(sel),
    .product_ab_invert(neg_ab), .product_cd_invert(neg_cd), .chain_input(chain),
    .chain_input_enable_n(ch_en_n), .cascade_bypass(byp), .sum_keep_control(keep),
    .round_control(rnd), .word_select(ws), .three_state_control_n(ts_n),
    .sum_output_out(s_out), .sum_output_oe(s_oe), .capture_ready(cap_rdy),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  dpm_link link (.pclk(pclk), .en_n(ch_en_n), .val(chv), .s_out(s_out), .s_oe(s_oe),
                 .chain(chain), .bus(bus));

  // 50 MHz clock
  always #10 pclk = ~pclk;

  // ==========================================================
  // access tasks
  // one edge-aligned datapath cycle: operands, controls, cascade word
  task automatic drv(input logic [47:0] o, input logic [5:0] k, input logic [15:0] ch);
    @(posedge pclk);
    {a, b, c, d} <= o;
    {neg_ab, neg_cd, keep, rnd, byp, ch_en_n} <= k;
    chv <= ch;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // sample the bus just after an edge, once its updates have landed
  task automatic see(input int n, input logic [OUTW-1:0] e, input string nm);
    repeat (n) @(posedge pclk);
    #1;
    `CHK(nm, e, bus)
  endtask
  // old value one edge short of the latency, new value exactly on it
  task automatic lat(input int n, input logic [OUTW-1:0] o, input logic [OUTW-1:0] e);
    see(n - 1, o, "before");
    see(1, e, "after");
  endtask
  // apb master: request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, ad, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed here; only the hang guard ends a stuck transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdchk(input logic [7:0] ad, input logic e_err, input logic [31:0] e,
                       input string nm);
    apb(1'b0, ad, 32'h0, rdv, erv);
    `CHK(nm, {e_err, e}, {erv, rdv})
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dv, input logic e_err);
    apb(1'b1, ad, dv, rdv, erv);
    `CHK("write response", e_err, erv)
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    presetn = 1'b0;
    {a, b, c, d, chv, sel, push_n, paddr, pwdata} = '0;
    {neg_ab, neg_cd, keep, rnd, byp, ts_n, psel, penable, pwrite} = '0;
    {ch_en_n, ws} = 2'b11;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // register defaults and an unmapped slot
    rdchk(REG_CTRL, 1'b0, 32'h0, "ctrl reset");
    rdchk(REG_STATUS, 1'b0, 32'h1, "status reset");
    rdchk(8'h0c, 1'b1, 32'h0, "unmapped read");
    wr(8'h0c, 32'hffff_ffff, 1'b1);
    done("registers");
    // stacks and selects loaded before any result is trusted
    drv({12'h100, 12'h100, 24'h0}, 6'h01, 16'h0);
    tick(20);
    drv({12'h100, 12'h200, 24'h0}, 6'h01, 16'h0);
    lat(6, 16'h0100, 16'h0200);
    drv(OPN, 6'h01, 16'h0);
    tick(8);
    for (int i = 1; i < 4; i++) begin
      drv(OPN, {i[1:0], 4'h1}, 16'h0);
      lat(6, inv_exp[i-1], inv_exp[i]);
    end
    done("products");
    // round on restart only; a repeated round would show as 4
    drv(OPR, 6'h01, 16'h0);
    see(8, 16'h0001, "plain sum");
    drv(OPR, 6'h05, 16'h0);
    lat(6, 16'h0001, 16'h0002);
    drv(OPR, 6'h0d, 16'h0);
    lat(6, 16'h0002, 16'h0003);
    see(1, 16'h0005, "second add");
    drv(OPR, 6'h05, 16'h0);
    see(6, 16'h0002, "restart");
    done("accumulate");
    // a frozen operand keeps its value while b moves on
    drv(OPX, 6'h01, 16'h0);
    tick(8);
    @(posedge pclk);
    push_n <= 4'h1;
    {a, b} <= {12'h200, 12'h003};
    see(10, 16'h0003, "frozen a");
    @(posedge pclk);
    push_n <= 4'h0;
    lat(5, 16'h0003, 16'h0006);
    foreach (dly[i]) begin
      @(posedge pclk);
      sel <= SELW'(dly[i]);
      drv(OPX, 6'h01, 16'h0);
      tick(20);
      drv(OPY, 6'h01, 16'h0);
      lat(6 + dly[i], 16'h0001, 16'h0006);
    end
    @(posedge pclk);
    sel <= '0;
    done("stacks");
    // cascade word lands on the upper word, three cycles early when bypassed
    drv(OPX, 6'h00, 16'h0010);
    tick(8);
    drv(OPX, 6'h00, 16'h0020);
    lat(6, 16'h0011, 16'h0021);
    drv(OPX, 6'h02, 16'h0020);
    tick(8);
    drv(OPX, 6'h02, 16'h0030);
    lat(3, 16'h0021, 16'h0031);
    drv(OPX, 6'h03, 16'h0030);
    see(8, 16'h0001, "chain ignored");
    done("cascade");
    // swap low: alternate words of the held sum, ignore new sums
    drv({12'h7ff, 12'h7ff, 24'h0}, 6'h01, 16'h0);
    tick(8);
    @(posedge pclk);
    ws <= 1'b0;
    tick(1);
    drv('0, 6'h01, 16'h0);
    see(4, 16'hf001, "lower word");
    see(1, 16'h3ff0, "upper word");
    see(1, 16'hf001, "lower again");
    see(1, 16'h3ff0, "upper again");
    @(posedge pclk);
    ws <= 1'b1;
    see(8, 16'h0000, "refreshed");
    // output enable acts before the next edge
    @(posedge pclk);
    ts_n <= 1'b1;
    #1;
    `CHK("drive enable", 1'b0, s_oe)
    `CHK("floated bus", 16'hffff, bus)
    @(posedge pclk);
    ts_n <= 1'b0;
    see(0, 16'h0000, "driven again");
    done("output");
    // capture until refused, then drain to empty
    drv({12'h100, 12'h004, 24'h0}, 6'h01, 16'h0);
    tick(8);
    wr(REG_CTRL, 32'h1, 1'b0);
    tick(20);
    rdchk(REG_CTRL, 1'b0, 32'h1, "ctrl");
    `CHK("fill side ready", 1'b0, cap_rdy)
    rdchk(REG_STATUS, 1'b0, 32'h106, "status full");
    wr(REG_CTRL, 32'h0, 1'b0);
    wr(REG_STATUS, 32'h4, 1'b0);
    rdchk(REG_STATUS, 1'b0, 32'h102, "status cleared");
    repeat (FIFO_DEP) rdchk(REG_DATA, 1'b0, 32'h4, "captured word");
    rdchk(REG_STATUS, 1'b0, 32'h1, "status empty");
    rdchk(REG_DATA, 1'b0, 32'h0, "empty read");
    done("capture");
    complete_run();
  end

  // hang guard: the sequence needs well under 3000 cycles
  initial begin
    #100_000;
    fails++;
    complete_run();
  end
endmodule // tb
`default_nettype wire
